// *** lockup_timer_pkg.sv ***
// package of constants and the slow-oscillator tick generator for the lockup timer
package lockup_timer_pkg;
   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] ADDR_RELOAD = 8'h00;
   localparam logic [7:0] ADDR_CONFIG = 8'h04;
   localparam logic [7:0] ADDR_DELTA = 8'h08;
   localparam logic [7:0] ADDR_PROTECT = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   // ****************************************
   // field layouts
   // ****************************************
   localparam int CNT_W = 12;
   localparam int PSC_W = 3;
   localparam int PDIV_W = 7;
   localparam int CFG_PSC_LSB = 12;
   localparam int CFG_EN_BIT = 16;
   localparam int CFG_DBG_BIT = 17;
   localparam int ST_UNDER_BIT = 16;
   localparam int ST_EARLY_BIT = 17;
   localparam int ST_PROT_BIT = 18;
   localparam logic [15:0] RELOAD_KEY = 16'h5FA0;
   localparam logic [15:0] UNLOCK_KEY = 16'h35CA;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [CNT_W-1:0] RST_RELOAD = 12'hFFF;
   localparam logic [CNT_W-1:0] RST_DELTA = 12'hFFF;
   localparam logic [PSC_W-1:0] RST_PSC = 3'h7;
   localparam logic RST_EN = 1'b1;
   localparam logic RST_DBG = 1'b0;
   localparam logic RST_PROT = 1'b0;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 4;
   localparam int RST_HOLD_NS = 64;
   localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_W = 5;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lockup_timer_pkg

`timescale 1ns/100ps
// ****************************************
// slow oscillator sampler: two flops, then rising-edge pulse
// ****************************************
module slow_tick_gen (
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset, active low
   input wire logic slow_internal_oscillator, // slow rc oscillator, asynchronous
   output logic tick // one-cycle pulse per slow rising edge
);
   logic meta_q;
   logic sync_q;
   logic prev_q;

   // two-flop synchroniser, then a delayed copy for edge detection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= slow_internal_oscillator;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign tick = sync_q & ~prev_q;
endmodule : slow_tick_gen

// *** lockup_timer.sv ***
// windowed lockup timer with axi4-lite register slave
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/100ps

// Notes on behaviour
// - twelve-bit down-counter advanced through a prescaler chosen by a three-bit setting.
// - counter underflow without reload raises the system reset.
// - reload while counter is above delta raises the system reset.
// - delta value held in a register bounds the reload window.
// - counter optionally frozen while the processor is halted in debug.
// - write protection, when on, blocks changes to configuration registers.
// - counter and prescaler advance on the slow internal oscillator, not system clock.
module lockup_timer (
   input wire logic aclk, // system clock, 250 mhz
   input wire logic aresetn, // sync reset, active low
   input wire logic slow_internal_oscillator, // slow rc oscillator pin
   input wire logic debug_halt, // processor halted in debug, same clock
   output logic sys_reset_req, // system reset request, held pulse
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read response valid
   input wire logic s_axi_rready // read response ready
);
   import lockup_timer_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   logic aw_held_q;
   logic [7:0] aw_addr_q;
   logic w_held_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_go;
   logic [CNT_W-1:0] reload_val_q;
   logic [CNT_W-1:0] delta_q;
   logic [PSC_W-1:0] psc_q;
   logic enable_q;
   logic dbg_stop_q;
   logic protect_q;
   logic [CNT_W-1:0] count_q;
   logic [PDIV_W-1:0] pdiv_q;
   logic under_flag_q;
   logic early_flag_q;
   logic [HOLD_W-1:0] hold_q;
   logic tick;
   logic step;
   logic advance;
   logic underflow;
   logic reload_req;
   logic early_reload;
   logic full_word;

   // true when the address hits a mapped register
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == ADDR_RELOAD) || (a == ADDR_CONFIG) || (a == ADDR_DELTA) ||
                  (a == ADDR_PROTECT) || (a == ADDR_STATUS);
   endfunction : is_mapped

   // ****************************************
   // slow oscillator tick
   // ****************************************
   slow_tick_gen u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .slow_internal_oscillator(slow_internal_oscillator),
      .tick(tick)
   );

   // ****************************************
   // axi4-lite write channel
   // ****************************************
   assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
   assign wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
   assign full_word = (w_strb_q == 4'hF);

   // capture address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_held_q <= 1'b0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held_q <= 1'b0;
         end
      end
   end

   // write response, slverr on unmapped address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ****************************************
   // configuration registers
   // ****************************************
   // writes take effect only as full words and only while unprotected
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reload_val_q <= RST_RELOAD;
         psc_q <= RST_PSC;
         enable_q <= RST_EN;
         dbg_stop_q <= RST_DBG;
         delta_q <= RST_DELTA;
      end else if (wr_go && full_word && !protect_q) begin
         if (aw_addr_q == ADDR_CONFIG) begin
            reload_val_q <= w_data_q[CNT_W-1:0];
            psc_q <= w_data_q[CFG_PSC_LSB +: PSC_W];
            enable_q <= w_data_q[CFG_EN_BIT];
            dbg_stop_q <= w_data_q[CFG_DBG_BIT];
         end
         if (aw_addr_q == ADDR_DELTA) begin
            delta_q <= w_data_q[CNT_W-1:0];
         end
      end
   end

   // protection: bit0 set turns it on, unlock key turns it off
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         protect_q <= RST_PROT;
      end else if (wr_go && full_word && aw_addr_q == ADDR_PROTECT) begin
         if (w_data_q[15:0] == UNLOCK_KEY) begin
            protect_q <= 1'b0;
         end else if (w_data_q[0]) begin
            protect_q <= 1'b1;
         end
      end
   end

   // ****************************************
   // counter core
   // ****************************************
   assign reload_req = wr_go && full_word && (aw_addr_q == ADDR_RELOAD) &&
                       (w_data_q[31:16] == RELOAD_KEY) && w_data_q[0];
   assign early_reload = reload_req && enable_q && (count_q > delta_q);
   assign step = tick && enable_q && !(dbg_stop_q && debug_halt);
   assign advance = step && (pdiv_q == PDIV_W'((1 << psc_q) - 1));
   assign underflow = advance && (count_q == '0);

   // prescaler divides slow ticks by two to the power of the setting
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pdiv_q <= '0;
      end else if (reload_req || !enable_q) begin
         pdiv_q <= '0;
      end else if (advance) begin
         pdiv_q <= '0;
      end else if (step) begin
         pdiv_q <= pdiv_q + PDIV_W'(1);
      end
   end

   // down-counter, reloaded on request or after underflow
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= RST_RELOAD;
      end else if (reload_req || underflow) begin
         count_q <= reload_val_q;
      end else if (advance) begin
         count_q <= count_q - CNT_W'(1);
      end
   end

   // reset request held for a fixed number of cycles
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_q <= '0;
      end else if (underflow || early_reload) begin
         hold_q <= HOLD_W'(RST_HOLD_CYC);
      end else if (hold_q != '0) begin
         hold_q <= hold_q - HOLD_W'(1);
      end
   end

   assign sys_reset_req = (hold_q != '0);

   // sticky cause flags, write one to clear, a new event wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         under_flag_q <= 1'b0;
         early_flag_q <= 1'b0;
      end else begin
         if (underflow) begin
            under_flag_q <= 1'b1;
         end else if (wr_go && full_word && aw_addr_q == ADDR_STATUS && w_data_q[ST_UNDER_BIT]) begin
            under_flag_q <= 1'b0;
         end
         if (early_reload) begin
            early_flag_q <= 1'b1;
         end else if (wr_go && full_word && aw_addr_q == ADDR_STATUS && w_data_q[ST_EARLY_BIT]) begin
            early_flag_q <= 1'b0;
         end
      end
   end

   // ****************************************
   // axi4-lite read channel
   // ****************************************
   assign s_axi_arready = ~s_axi_rvalid;

   // one-cycle read answer from registered data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            ADDR_CONFIG: begin
               s_axi_rdata <= {14'h0000, dbg_stop_q, enable_q, 1'b0, psc_q, reload_val_q};
            end
            ADDR_DELTA: begin
               s_axi_rdata <= {20'h00000, delta_q};
            end
            ADDR_PROTECT: begin
               s_axi_rdata <= {31'h00000000, protect_q};
            end
            ADDR_STATUS: begin
               s_axi_rdata <= {13'h0000, protect_q, early_flag_q, under_flag_q, 4'h0, count_q};
            end
            default: begin
               s_axi_rdata <= 32'h00000000;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : lockup_timer

// *** lockup_timer_props.sv ***
// port-level checker for the lockup timer
`timescale 1ns/100ps
module lockup_timer_props import lockup_timer_pkg::*; (
   input wire logic aclk, // clock
   input wire logic aresetn, // reset, low
   input wire logic sys_reset_req, // reset out
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic [1:0] s_axi_bresp, // b resp
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic [7:0] s_axi_araddr, // ar addr
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata, // r data
   input wire logic [1:0] s_axi_rresp, // r resp
   input wire logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready // r ready
);
   // ****************************************
   // assertions and covers
   // ****************************************
   logic [HOLD_W-1:0] high_run_q;

   // consecutive cycles with the reset request high, saturating
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         high_run_q <= '0;
      end else if (!sys_reset_req) begin
         high_run_q <= '0;
      end else if (high_run_q != '1) begin
         high_run_q <= high_run_q + HOLD_W'(1);
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // reset request is one pulse of the fixed hold length
   AST_RST_LEN: assert property ($fell(sys_reset_req) |-> high_run_q == HOLD_W'(RST_HOLD_CYC))
      else $error("reset request pulse length wrong");
   // responses stand until taken
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   // aligned reads inside the map are answered okay
   AST_AR_RDY: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= ADDR_STATUS &&
      s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == RESP_OKAY)
      else $error("mapped read refused");
   AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_UNMAP: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   C_RST: cover property ($rose(sys_reset_req));
   C_WERR: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   C_RWAIT: cover property (s_axi_rvalid && !s_axi_rready);
endmodule : lockup_timer_props

// *** test_lockup_timer.sv ***
// self-checking bench for the lockup timer
`timescale 1ns/100ps
module test_lockup_timer;
   import lockup_timer_pkg::*;
   localparam logic [31:0] KEYW = {RELOAD_KEY, 16'h0001};
   logic aclk, aresetn, osc, dbg, sys_reset_req;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [11:0] rv;
   int seed = 70, fails = 0, cmp_count = 0, rcnt = 0, r0;
   lockup_timer DUT (.aclk, .aresetn, .slow_internal_oscillator(osc), .debug_halt(dbg), .sys_reset_req,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   // ****************************************
   // clock, counter of cycles with the reset request high, watchdog
   // ****************************************
   initial begin
      aclk = 0;
      forever #2 aclk = ~aclk;
   end
   always @(posedge aclk) if (sys_reset_req === 1'b1) rcnt <= rcnt + 1;
   initial begin
      #200000;
      fails++;
      end_of_test();
   end
   function automatic logic [31:0] cfg(logic [11:0] v, logic [2:0] p, logic d);
      return {14'h0, d, 1'b1, 1'b0, p, v};
   endfunction : cfg
   function automatic logic [31:0] st(logic [11:0] c, logic [2:0] f);
      return {13'h0, f, 4'h0, c};
   endfunction : st
   task end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : chk
   // one axi transfer; ready may come late
   task bus(input bit w, input logic [7:0] a, input logic [31:0] d);
      logic aw, wr, ar, dn;
      dn = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_arvalid <= !w;
      s_axi_bready <= w && ($random(seed) & 1) != 0;
      s_axi_rready <= !w && ($random(seed) & 1) != 0;
      while (!dn) begin
         @(negedge aclk);
         aw = s_axi_awready;
         wr = s_axi_wready;
         ar = s_axi_arready;
         dn = w ? s_axi_bvalid & s_axi_bready : s_axi_rvalid & s_axi_rready;
         rsp = w ? s_axi_bresp : s_axi_rresp;
         rd = s_axi_rdata;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 0;
         if (wr) s_axi_wvalid <= 0;
         if (ar) s_axi_arvalid <= 0;
         s_axi_bready <= w && !dn;
         s_axi_rready <= !w && !dn;
      end
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1, a, d);
   endtask : wr
   task rc(input logic [7:0] a, input logic [31:0] e, input string n);
      bus(0, a, 32'h0);
      chk(n, e, rd);
   endtask : rc
   // slow oscillator pulses with random gaps
   task tk(input int n);
      repeat (n) begin
         osc <= 1;
         repeat (4) @(posedge aclk);
         osc <= 0;
         repeat (4 + ($random(seed) & 3)) @(posedge aclk);
      end
   endtask : tk
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {osc, dbg, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 7'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      aresetn = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      rc(ADDR_CONFIG, cfg(12'hFFF, 3'h7, 1'b0), "config");
      rc(ADDR_DELTA, 32'hFFF, "delta");
      rc(ADDR_STATUS, st(12'hFFF, 3'h0), "status");
      rc(ADDR_RELOAD, 32'h0, "reload");
      rc(8'h20, 32'h0, "unmapped");
      chk("rresp", RESP_SLVERR, rsp);
      wr(8'h24, 32'h1);
      chk("bresp", RESP_SLVERR, rsp);
      $display("test reset done");
      // each prescaler setting needs 2^p ticks per step
      rv = 12'h100 | (12'($random(seed)) & 12'h0FF);
      for (int p = 0; p < 8; p++) begin
         wr(ADDR_CONFIG, cfg(rv, 3'(p), 1'b0));
         wr(ADDR_RELOAD, KEYW);
         tk(1 << p);
         rc(ADDR_STATUS, st(rv - 12'h1, 3'h0), "count");
      end
      wr(ADDR_CONFIG, cfg(rv, 3'h1, 1'b0));
      wr(ADDR_RELOAD, KEYW);
      tk(1);
      wr(ADDR_RELOAD, KEYW);
      tk(1);
      rc(ADDR_STATUS, st(rv, 3'h0), "restart");
      tk(3);
      rc(ADDR_STATUS, st(rv - 12'h2, 3'h0), "step");
      $display("test prescaler done");
      wr(ADDR_CONFIG, cfg(rv, 3'h0, 1'b1));
      wr(ADDR_RELOAD, KEYW);
      dbg <= 1;
      tk(2);
      rc(ADDR_STATUS, st(rv, 3'h0), "halted");
      dbg <= 0;
      tk(1);
      rc(ADDR_STATUS, st(rv - 12'h1, 3'h0), "resumed");
      $display("test debug done");
      // underflow after reload value plus one ticks
      wr(ADDR_CONFIG, cfg(12'h2, 3'h0, 1'b0));
      wr(ADDR_RELOAD, KEYW);
      r0 = rcnt;
      tk(2);
      chk("no request", r0, rcnt);
      tk(1);
      rc(ADDR_STATUS, st(12'h2, 3'h1), "underflow");
      repeat (16) @(posedge aclk);
      chk("request length", r0 + 16, rcnt);
      wr(ADDR_STATUS, 32'h0001_0000);
      rc(ADDR_STATUS, st(12'h2, 3'h0), "flag clear");
      $display("test underflow done");
      // reload above delta, then at delta
      wr(ADDR_DELTA, 32'h1);
      r0 = rcnt;
      wr(ADDR_RELOAD, KEYW);
      repeat (20) @(posedge aclk);
      chk("early request", r0 + 16, rcnt);
      rc(ADDR_STATUS, st(12'h2, 3'h2), "early flag");
      wr(ADDR_STATUS, 32'h0002_0000);
      tk(1);
      r0 = rcnt;
      wr(ADDR_RELOAD, KEYW);
      repeat (20) @(posedge aclk);
      chk("window reload", r0, rcnt);
      $display("test window done");
      wr(ADDR_PROTECT, 32'h1);
      rc(ADDR_STATUS, st(12'h2, 3'h4), "protect on");
      wr(ADDR_DELTA, 32'h5);
      rc(ADDR_DELTA, 32'h1, "locked delta");
      wr(ADDR_PROTECT, {16'h0, UNLOCK_KEY});
      wr(ADDR_DELTA, 32'h5);
      rc(ADDR_DELTA, 32'h5, "open delta");
      // disabled timer ignores ticks: no decrement, no underflow
      wr(ADDR_CONFIG, 32'h0000_0002);
      tk(3);
      rc(ADDR_STATUS, st(12'h2, 3'h0), "disabled");
      $display("test protect done");
      end_of_test();
   end
endmodule : test_lockup_timer
bind lockup_timer lockup_timer_props u_props (.aclk, .aresetn, .sys_reset_req, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
